// ### mcd_pkg.sv
package mcd_pkg;

    // Register bus geometry
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [31:0] TAG_DATA_BASE   = 32'h2101_0000;
    localparam logic [31:0] TAG_DATA_LAST   = 32'h2101_7FFF;
    localparam logic [31:0] BANK_CFG_BASE   = 32'h2101_8000;
    localparam logic [31:0] MODE_DIAG_ADDR  = 32'h2101_8048;
    localparam logic [31:0] TAG_MODE_ADDR   = 32'h2101_804C;
    localparam logic [31:0] IRQ_STAT_ADDR   = 32'h2101_8050;
    localparam logic [31:0] IRQ_MASK_ADDR   = 32'h2101_8054;
    localparam int          NUM_BANKS       = 8;
    localparam int          TAG_DEPTH       = 16;

    // Bank configuration fields
    localparam int BANK_VALID_BIT  = 31;
    localparam int BANK_BASE_HI    = 28;
    localparam int BANK_BASE_LO    = 24;
    localparam int BANK_SIZE_HI    = 2;
    localparam int BANK_SIZE_LO    = 1;
    localparam int BANK_MODE64_BIT = 0;
    localparam logic [1:0] SIZE_4MB  = 2'h2;
    localparam logic [1:0] SIZE_NONE = 2'h3;

    // Mode control and diagnostic status fields
    localparam int FDM_BIT        = 31;
    localparam int FDM_PASS2_BIT  = 30;
    localparam int CHKBIT_BIT     = 29;
    localparam int SOFT_LOG_BIT   = 27;
    localparam int CHK_HI         = 24;
    localparam int CHK_LO         = 17;
    localparam int TMO_HI         = 8;
    localparam int TMO_LO         = 7;
    localparam int MEM_ERR_DIS    = 6;
    localparam int REF_SEL_BIT    = 5;
    localparam int PAR_HI         = 4;
    localparam int PAR_LO         = 2;
    localparam int REF_DIS_BIT    = 1;
    localparam int REF_FORCE_BIT  = 0;
    localparam logic [31:0] MODE_DIAG_WMASK = 32'hEBFE_01FF;

    // Tag-bit address and mode fields
    localparam int TAG_IGNORE_BIT = 16;
    localparam int TAG_ERRDIS_BIT = 15;
    localparam logic [31:0] TAG_MODE_WMASK = 32'h0001_FFFF;
    localparam logic [31:0] TAG_DATA_WMASK = 32'h00FF_FFFF;

    // Timing counts in system bus cycles
    localparam int REF_SLOW_CYC = 328;
    localparam int REF_FAST_CYC = 244;
    localparam int TMO_MAX_CYC  = 2600;

    // Interrupt status bits
    localparam int IRQ_REFRESH = 0;
    localparam int IRQ_TIMEOUT = 1;
    localparam int IRQ_W       = 2;

    localparam logic [31:0] ZERO32 = 32'h0000_0000;

endpackage

// ### mcd_refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mcd_refresh_timer
#(
    parameter int SLOW_CYC = 328,
    parameter int FAST_CYC = 244
)
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Control
    input  wire logic fast_sel,
    input  wire logic disable_ref,
    input  wire logic force_ref,
    // Request
    output logic      refresh_req
);

    // ******************************
    // Interval counter
    // ******************************
    logic [8:0] count;
    logic [8:0] limit;

    assign limit = fast_sel ? 9'(FAST_CYC - 1) : 9'(SLOW_CYC - 1);

    always_ff @(posedge sys_clk)
    begin
        if (rst || count >= limit)
            count <= 9'h000;
        else
            count <= count + 9'h001;
    end

    // Forcing still works with periodic refresh off, for diagnostics
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            refresh_req <= 1'b0;
        else
            refresh_req <= force_ref || (!disable_ref && count >= limit);
    end

endmodule
`default_nettype wire

// ### mcd_top.sv
// Notes on behaviour
// - Eight bank configuration registers at consecutive word addresses.
// - Bit 31 bank valid, reset clear; bank decodes only when valid.
// - Base bits 28:24 reset zero; 4MB banks compare only 28:26.
// - Size 00/01 is 1MB, 10 is 4MB, 11 is absent; reset 00.
// - Mode bits 31,30,29: fast diag, second pass, check-bit; reset off.
// - Bit 27 enables soft error logging; reset off.
// - Bits 24:17 supply check bits only in check-bit mode.
// - Timeout scaler bits 8:7; reset 00 gives 2600 cycles maximum.
// - Bit 6 clear detects and corrects errors; set disables that.
// - Bit 5 picks refresh every 328 (0) or 244 (1) cycles.
// - Bits 4:2 force wrong bus parity; reset zero.
// - Bit 1 stops refresh, bit 0 forces one; both reset zero.
// - Tag mode bit 16 ignores tag bits; reset zero.
// - Tag mode bit 15 disables tag error reporting; reset zero.
// - Segment address 14:6 and mask 5:3 reset zero; stored only, not used for window.
// - Tag operation mode 2:0 resets to reconstruction; stored only, does not govern window.
// - Tag window words hold two 12-bit fields, reset zero.
`timescale 1ns/1ps
`default_nettype none
module mcd_top
    import mcd_pkg::*;
#(
    parameter int TMO_BASE_CYC = mcd_pkg::TMO_MAX_CYC,
    parameter int TAG_WORDS    = mcd_pkg::TAG_DEPTH
)
(
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // Register port
    input  wire logic [mcd_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [mcd_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [mcd_pkg::DATA_W-1:0] reg_rdata,
    // Memory access decode
    input  wire logic [31:0]               mem_addr,
    input  wire logic                      mem_req,
    output logic      [7:0]                bank_hit,
    output logic                           bank_mode64,
    // Bus transaction timing
    input  wire logic                      bus_busy,
    output logic                           bus_timeout,
    // Memory control outputs
    output logic                           refresh_req,
    output logic                           ecc_enable,
    output logic                           soft_log_en,
    output logic      [7:0]                diag_checkbits,
    output logic                           diag_chk_mode,
    output logic                           fast_diag,
    output logic                           fast_diag_pass2,
    output logic      [2:0]                force_parity,
    output logic                           tag_check_en,
    output logic                           tag_err_report,
    // Interrupt
    output logic                           irq
);

    // ******************************
    // Register state
    // ******************************
    logic [31:0]        bank_cfg [NUM_BANKS];
    logic [31:0]        mode_diag;
    logic [31:0]        tag_mode;
    logic [23:0]        tag_mem [TAG_WORDS];
    logic [IRQ_W-1:0]   irq_stat;
    logic [IRQ_W-1:0]   irq_mask;
    logic               ref_pulse;
    logic               tmo_pulse;

    function automatic logic in_range(input logic [31:0] a,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic        sel_bank;
    logic [2:0]  bank_idx;
    logic        sel_tag;
    logic [$clog2(TAG_WORDS)-1:0] tag_idx;

    assign sel_bank = in_range(reg_addr, BANK_CFG_BASE,
                               BANK_CFG_BASE + 32'h0000_001C)
                      && (reg_addr[1:0] == 2'h0);
    assign bank_idx = reg_addr[4:2];
    assign sel_tag  = in_range(reg_addr, TAG_DATA_BASE, TAG_DATA_LAST)
                      && (reg_addr[1:0] == 2'h0);
    // Only a small window is built; higher locations alias onto it
    assign tag_idx  = reg_addr[$clog2(TAG_WORDS)+1:2];

    // ******************************
    // Register writes
    // ******************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_BANKS; i++)
                bank_cfg[i] <= ZERO32;
        end
        else if (reg_wr && sel_bank)
        begin
            bank_cfg[bank_idx] <= reg_wdata & 32'h9F00_0007;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            mode_diag <= ZERO32;
        else if (reg_wr && reg_addr == MODE_DIAG_ADDR)
            mode_diag <= reg_wdata & MODE_DIAG_WMASK;
        else
            mode_diag[REF_FORCE_BIT] <= 1'b0; // Force is a one-shot
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            tag_mode <= ZERO32;
        else if (reg_wr && reg_addr == TAG_MODE_ADDR)
            tag_mode <= reg_wdata & TAG_MODE_WMASK;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < TAG_WORDS; i++)
                tag_mem[i] <= 24'h00_0000;
        end
        else if (reg_wr && sel_tag)
        begin
            tag_mem[tag_idx] <= reg_wdata[23:0] & TAG_DATA_WMASK[23:0];
        end
    end

    // ******************************
    // Interrupt status and mask
    // ******************************
    logic [IRQ_W-1:0] irq_set;
    assign irq_set = {tmo_pulse, ref_pulse};

    // A new event beats a simultaneous write-one-to-clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_stat <= '0;
        else if (reg_wr && reg_addr == IRQ_STAT_ADDR)
            irq_stat <= (irq_stat & ~reg_wdata[IRQ_W-1:0]) | irq_set;
        else
            irq_stat <= irq_stat | irq_set;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_mask <= '0;
        else if (reg_wr && reg_addr == IRQ_MASK_ADDR)
            irq_mask <= reg_wdata[IRQ_W-1:0];
    end

    assign irq = |(irq_stat & irq_mask);

    // ******************************
    // Register reads
    // ******************************
    // Tag window reads see the operation mode in the top byte only as zero
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reg_rdata <= ZERO32;
        else if (reg_rd)
        begin
            if (sel_bank)
                reg_rdata <= bank_cfg[bank_idx];
            else if (reg_addr == MODE_DIAG_ADDR)
                reg_rdata <= mode_diag;
            else if (reg_addr == TAG_MODE_ADDR)
                reg_rdata <= tag_mode;
            else if (sel_tag)
                reg_rdata <= {8'h00, tag_mem[tag_idx]};
            else if (reg_addr == IRQ_STAT_ADDR)
                reg_rdata <= {30'h0000_0000, irq_stat};
            else if (reg_addr == IRQ_MASK_ADDR)
                reg_rdata <= {30'h0000_0000, irq_mask};
            else
                reg_rdata <= ZERO32;
        end
        else
            reg_rdata <= ZERO32;
    end

    // ******************************
    // Bank address decode
    // ******************************
    function automatic logic bank_match(input logic [31:0] cfg,
                                        input logic [31:0] a);
        logic [1:0] sz;
        sz = cfg[BANK_SIZE_HI:BANK_SIZE_LO];
        if (!cfg[BANK_VALID_BIT] || sz == SIZE_NONE)
            bank_match = 1'b0;
        else if (sz == SIZE_4MB)
            bank_match = cfg[28:26] == a[28:26];
        else
            bank_match = cfg[28:24] == a[28:24];
    endfunction

    // Registered so decode timing does not depend on the caller
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bank_hit    <= 8'h00;
            bank_mode64 <= 1'b0;
        end
        else
        begin
            bank_mode64 <= 1'b0;
            for (int i = 0; i < NUM_BANKS; i++)
            begin
                bank_hit[i] <= mem_req && bank_match(bank_cfg[i], mem_addr);
                if (mem_req && bank_match(bank_cfg[i], mem_addr))
                    bank_mode64 <= bank_cfg[i][BANK_MODE64_BIT];
            end
        end
    end

    // ******************************
    // Mode outputs
    // ******************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ecc_enable      <= 1'b1;
            soft_log_en     <= 1'b0;
            diag_checkbits  <= 8'h00;
            diag_chk_mode   <= 1'b0;
            fast_diag       <= 1'b0;
            fast_diag_pass2 <= 1'b0;
            force_parity    <= 3'h0;
            tag_check_en    <= 1'b1;
            tag_err_report  <= 1'b1;
        end
        else
        begin
            ecc_enable      <= !mode_diag[MEM_ERR_DIS];
            soft_log_en     <= mode_diag[SOFT_LOG_BIT];
            diag_chk_mode   <= mode_diag[CHKBIT_BIT];
            diag_checkbits  <= mode_diag[CHKBIT_BIT] ?
                               mode_diag[CHK_HI:CHK_LO] : 8'h00;
            fast_diag       <= mode_diag[FDM_BIT];
            fast_diag_pass2 <= mode_diag[FDM_PASS2_BIT];
            force_parity    <= mode_diag[PAR_HI:PAR_LO];
            tag_check_en    <= !tag_mode[TAG_IGNORE_BIT];
            tag_err_report  <= !tag_mode[TAG_ERRDIS_BIT];
        end
    end

    // ******************************
    // Bus timeout
    // ******************************
    // Scaler 00 is the longest; each step halves the limit
    logic [11:0] tmo_count;
    logic [11:0] tmo_limit;

    assign tmo_limit = 12'(TMO_BASE_CYC >> mode_diag[TMO_HI:TMO_LO]);

    always_ff @(posedge sys_clk)
    begin
        if (rst || !bus_busy)
            tmo_count <= 12'h000;
        else if (tmo_count != tmo_limit)
            tmo_count <= tmo_count + 12'h001;
    end

    assign tmo_pulse = bus_busy && (tmo_count == tmo_limit - 12'h001);

    always_ff @(posedge sys_clk)
    begin
        if (rst || !bus_busy)
            bus_timeout <= 1'b0;
        else if (tmo_pulse)
            bus_timeout <= 1'b1;
    end

    // ******************************
    // Refresh
    // ******************************
    mcd_refresh_timer
    #(
        .SLOW_CYC (REF_SLOW_CYC),
        .FAST_CYC (REF_FAST_CYC)
    )
    u_refresh
    (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .fast_sel    (mode_diag[REF_SEL_BIT]),
        .disable_ref (mode_diag[REF_DIS_BIT]),
        .force_ref   (mode_diag[REF_FORCE_BIT]),
        .refresh_req (ref_pulse)
    );

    assign refresh_req = ref_pulse;

endmodule
`default_nettype wire

// ### mcd_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checker
// ********
module mcd_checker
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        bus_busy,
    input wire logic        bus_timeout,
    input wire logic        refresh_req,
    input wire logic        ecc_enable,
    input wire logic        soft_log_en,
    input wire logic [7:0]  diag_checkbits,
    input wire logic        diag_chk_mode,
    input wire logic        fast_diag,
    input wire logic        fast_diag_pass2,
    input wire logic [2:0]  force_parity,
    input wire logic        tag_check_en,
    input wire logic        tag_err_report,
    input wire logic        irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_ref_single: assert property (refresh_req |=> !refresh_req)
        else $error("refresh pulse longer than one cycle");
    a_tmo_clear: assert property (!bus_busy |=> !bus_timeout)
        else $error("timeout stays after bus idle");
    a_tmo_early: assert property ($rose(bus_busy) |-> !bus_timeout [*4])
        else $error("timeout too early");
    a_tmo_hold: assert property (bus_timeout && bus_busy |=> bus_timeout)
        else $error("timeout dropped while busy");
    a_reset_state: assert property ($fell(rst) |-> ecc_enable && tag_check_en
        && tag_err_report && !soft_log_en && !fast_diag && !diag_chk_mode
        && force_parity == 3'h0 && !irq)
        else $error("control outputs wrong after reset");
    a_chk_gated: assert property (!diag_chk_mode |-> diag_checkbits == 8'h00)
        else $error("check bits driven outside check mode");
    a_ctrl_hold: assert property (!reg_wr && !$past(reg_wr) && !$past(reg_wr, 2)
        |=> $stable({fast_diag, fast_diag_pass2, diag_chk_mode, soft_log_en,
        ecc_enable, force_parity, tag_check_en, tag_err_report}))
        else $error("control changed without a write");
endmodule
bind mcd_top mcd_checker u_mcd_checker (.sys_clk, .rst, .reg_wr, .reg_rd,
    .reg_rdata, .bus_busy, .bus_timeout, .refresh_req, .ecc_enable,
    .soft_log_en, .diag_checkbits, .diag_chk_mode, .fast_diag,
    .fast_diag_pass2, .force_parity, .tag_check_en, .tag_err_report, .irq);
`default_nettype wire

// ### mcd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Bus and memory side model
// ********
module mcd_far_model
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [15:0] hold_len,
    input  wire logic [31:0] probe_addr,
    output logic      [31:0] mem_addr,
    output logic             mem_req,
    output logic             bus_busy
);
    logic [15:0] left;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            left <= 16'h0000;
            mem_req <= 1'b0;
            mem_addr <= 32'h0000_0000;
        end
        else
        begin
            mem_req <= start;
            // Idle address toggles so a stale value never looks valid
            mem_addr <= start ? probe_addr : ~mem_addr;
            if (start)
                left <= hold_len;
            else if (left != 16'h0000)
                left <= left - 16'h0001;
        end
    end
    assign bus_busy = (left != 16'h0000);
endmodule
`default_nettype wire

// ### mcd_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Testbench
// ********
module mcd_top_tb_top;
    import mcd_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] reg_addr = 32'h0000_0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        start = 1'b0;
    logic [15:0] hold_len = 16'h0000;
    logic [31:0] probe = 32'h0000_0000;
    logic [31:0] reg_rdata, mem_addr;
    logic [7:0]  bank_hit, diag_checkbits;
    logic [2:0]  force_parity;
    logic        mem_req, bank_mode64, bus_busy, bus_timeout, refresh_req;
    logic        ecc_enable, soft_log_en, diag_chk_mode, fast_diag, irq;
    logic        fast_diag_pass2, tag_check_en, tag_err_report;
    int          miscompares = 0;
    int          checks_done = 0;

    // Short timeout base keeps every scaler step quick to reach
    mcd_top #(.TMO_BASE_CYC(40)) u_mcd_top (.sys_clk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_addr, .mem_req,
        .bank_hit, .bank_mode64, .bus_busy, .bus_timeout, .refresh_req,
        .ecc_enable, .soft_log_en, .diag_checkbits, .diag_chk_mode,
        .fast_diag, .fast_diag_pass2, .force_parity, .tag_check_en,
        .tag_err_report, .irq);
    mcd_far_model u_mcd_far_model (.sys_clk, .rst, .start, .hold_len,
        .probe_addr(probe), .mem_addr, .mem_req, .bus_busy);

    always #12.5 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e,
                      input string nm);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask
    task automatic ticks(input int k, output int c);
        c = 0;
        repeat (k)
        begin
            @(posedge sys_clk);
            #1;
            c += int'(refresh_req === 1'b1);
        end
    endtask
    function automatic logic [31:0] ctrl();
        return {14'h0000, fast_diag, fast_diag_pass2, diag_chk_mode,
            soft_log_en, diag_checkbits, ecc_enable, force_parity,
            tag_check_en, tag_err_report};
    endfunction
    task automatic t_regs();
        logic [31:0] ad [11];
        logic [31:0] mk [11];
        for (int i = 0; i < 8; i++)
        begin
            ad[i] = BANK_CFG_BASE + 32'(4 * i);
            mk[i] = 32'h9F00_0007;
        end
        ad[8] = MODE_DIAG_ADDR;
        mk[8] = MODE_DIAG_WMASK & 32'hFFFF_FFFE;
        ad[9] = TAG_MODE_ADDR;
        mk[9] = TAG_MODE_WMASK;
        ad[10] = TAG_DATA_BASE + 32'h0000_003C;
        mk[10] = TAG_DATA_WMASK;
        for (int i = 0; i < 11; i++)
        begin
            rd(ad[i], 32'h0000_0000, "reset value");
            wr(ad[i], 32'hFFFF_FFFF);
            rd(ad[i], mk[i], "written value");
        end
        wr(32'h2101_8040, 32'hFFFF_FFFF);
        rd(32'h2101_8040, 32'h0000_0000, "unmapped");
        rd(32'h2101_8002, 32'h0000_0000, "misaligned");
        chk("control on", 32'h0003_FFDC, ctrl());
        for (int i = 0; i < 11; i++)
            wr(ad[i], 32'h0000_0000);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("control off", 32'h0000_0023, ctrl());
    endtask
    task automatic probe_chk(input logic [31:0] a, input logic [7:0] e,
                             input string nm);
        @(posedge sys_clk);
        probe <= a;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(nm, {24'h00_0000, e}, {24'h00_0000, bank_hit});
    endtask
    task automatic t_decode();
        probe_chk(32'h0000_0000, 8'h00, "no valid bank");
        wr(BANK_CFG_BASE + 32'h0000_0008, 32'h8500_0000);
        wr(BANK_CFG_BASE + 32'h0000_000C, 32'h8C00_0005);
        wr(BANK_CFG_BASE + 32'h0000_0010, 32'h0500_0000);
        wr(BANK_CFG_BASE + 32'h0000_0014, 32'h8600_0006);
        probe_chk(32'h0500_0000, 8'h04, "1MB hit");
        probe_chk(32'h0600_0000, 8'h00, "absent bank");
        probe_chk(32'h0F00_0000, 8'h08, "4MB hit");
        chk("wide mode", 32'h0000_0001, {31'h0, bank_mode64});
    endtask
    task automatic t_refresh();
        int n;
        wr(MODE_DIAG_ADDR, 32'h0000_0000);
        for (int s = 0; s < 2; s++)
        begin
            wr(MODE_DIAG_ADDR, {26'h0, 1'(s), 5'h00});
            n = 0;
            while (refresh_req !== 1'b1 && n < 1000)
                ticks(1, n);
            n = 0;
            do
            begin
                @(posedge sys_clk);
                #1;
                n++;
            end
            while (refresh_req !== 1'b1 && n < 1000);
            chk("refresh period", s ? 32'd244 : 32'd328, n);
        end
        wr(IRQ_MASK_ADDR, 32'h0000_0001);
        wr(MODE_DIAG_ADDR, 32'h0000_0002);
        repeat (4) @(posedge sys_clk);
        wr(IRQ_STAT_ADDR, 32'h0000_0001);
        ticks(400, n);
        chk("refresh stopped", 32'h0000_0000, {31'h0, irq});
        chk("pulses stopped", 32'h0000_0000, n);
        wr(MODE_DIAG_ADDR, 32'h0000_0003);
        ticks(8, n);
        chk("forced pulse", 32'h0000_0001, n);
        chk("refresh irq", 32'h0000_0001, {31'h0, irq});
        rd(IRQ_STAT_ADDR, 32'h0000_0001, "status set");
        rd(MODE_DIAG_ADDR, 32'h0000_0002, "force clears");
        wr(IRQ_STAT_ADDR, 32'h0000_0001);
        @(posedge sys_clk);
        #1;
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    endtask
    task automatic t_tmo();
        int lim;
        wr(IRQ_MASK_ADDR, 32'h0000_0002);
        for (int s = 0; s < 4; s++)
        begin
            lim = 40 >> s;
            wr(MODE_DIAG_ADDR, {23'h0, 2'(s), 7'h02});
            @(posedge sys_clk);
            hold_len <= 16'(lim + 20);
            start <= 1'b1;
            @(posedge sys_clk);
            start <= 1'b0;
            repeat (lim - 4) @(posedge sys_clk);
            #1;
            chk("timeout early", 32'h0000_0000, {31'h0, bus_timeout});
            repeat (8) @(posedge sys_clk);
            #1;
            chk("timeout set", 32'h0000_0001, {31'h0, bus_timeout});
            chk("timeout irq", 32'h0000_0001, {31'h0, irq});
            repeat (lim + 20) @(posedge sys_clk);
            #1;
            chk("timeout gone", 32'h0000_0000, {31'h0, bus_timeout});
            wr(IRQ_STAT_ADDR, 32'h0000_0002);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_decode();
        t_refresh();
        t_tmo();
        final_report();
    end
    // Whole run needs a few thousand cycles; 20000 means a hang
    initial
    begin
        #500_000;
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
